// ==== rtl/deac_regs.vh ====
`ifndef DEAC_REGS_VH
`define DEAC_REGS_VH

// ****************************************
// Register addresses and reset values.
// ****************************************
`define DEAC_CTL_ADDR     8'hdf
`define DEAC_CTL_RESET    8'h00
`define DEAC_BANK_ADDR    8'hcb
`define DEAC_BANK_RESET   8'h00
`define DEAC_WIN_LAST     8'h3f

// ****************************************
// Control register fields.
// ****************************************
`define DEAC_BIT_ENA      0
`define DEAC_BIT_BUSY     1
`define DEAC_BIT_ROW_WRITE    2
`define DEAC_BIT_PSTART   3
`define DEAC_BIT_STBY     6

// ****************************************
// Bank codes and data values.
// ****************************************
`define DEAC_BANK_PAGE0   8'h01
`define DEAC_BANK_PAGE1   8'h02
`define DEAC_ROW_BYTES    8
`define DEAC_BLANK_DATA   8'hff

// ****************************************
// Programming cycle timing.
// ****************************************
`define DEAC_CLK_NS       10
`define DEAC_PROG_TIME_NS 10000
`define DEAC_PROG_CYCLES  (`DEAC_PROG_TIME_NS / `DEAC_CLK_NS)

`endif

// ==== rtl/deac_row_latch.v ====
`timescale 1ns/1ps
`include "deac_regs.vh"

// ****************************************
// Volatile row latches with written marks.
// ****************************************
module deac_row_latch #(
  parameter BYTES = `DEAC_ROW_BYTES
) (
  input  wire               i_clk,
  input  wire               i_rst_n,
  input  wire               i_clear,
  input  wire               i_load,
  input  wire [2:0]         i_index,
  input  wire [7:0]         i_data,
  output wire [BYTES*8-1:0] o_data,
  output wire [BYTES-1:0]   o_mask
);

  genvar g;
  generate
    for (g = 0; g < BYTES; g = g + 1)
    begin : g_byte
      reg [7:0] data_reg;
      reg       mark_reg;
      always @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          data_reg <= 8'h00;
          mark_reg <= 1'b0;
        end
        else if (i_clear)
        begin
          data_reg <= 8'h00;
          mark_reg <= 1'b0;
        end
        else if (i_load && (i_index == g))
        begin
          data_reg <= i_data;
          mark_reg <= 1'b1;
        end
      end
      assign o_data[g*8 +: 8] = data_reg;
      assign o_mask[g]        = mark_reg;
    end
  endgenerate

endmodule // deac_row_latch

// ==== rtl/deac_prog_timer.v ====
`timescale 1ns/1ps
`include "deac_regs.vh"

// ****************************************
// Programming cycle length counter.
// ****************************************
module deac_prog_timer #(
  parameter        CW     = 16,
  parameter [15:0] CYCLES = `DEAC_PROG_CYCLES
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_start,
  output wire o_done
);

  reg [CW-1:0] cnt_reg;
  reg          run_reg;

  assign o_done = run_reg && (cnt_reg == {CW{1'b0}});

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= {CW{1'b0}};
      run_reg <= 1'b0;
    end
    else if (i_start)
    begin
      cnt_reg <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
      run_reg <= 1'b1;
    end
    else if (o_done)
      run_reg <= 1'b0;
    else if (run_reg)
      cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
  end

endmodule // deac_prog_timer

// ==== rtl/deac_access.v ====
`timescale 1ns/1ps
`include "deac_regs.vh"

// How it works
// - EEPROM pages of 64 bytes appear at data addresses 00h to 3Fh.
// - Standby set: reads return blank, writes dropped; no bank selected: reads unanswered, writes dropped.
// - Control bit 6 puts the EEPROM in standby; it reads back as zero.
// - Control bit 0 enables programming; without it no cycle starts.
// - Busy bit 1 is high exactly while a programming cycle runs.
// - EEPROM accesses during busy are aborted; the running cycle completes.
// - Idle, awake EEPROM reads take the same latency as control reads.
// - Byte mode programs one byte; parallel mode up to 8 bytes of a row.
// - Data goes straight to its target address; no extra buffer RAM.
// - Control writes are ignored while busy; busy stays readable.
// - Parallel mode bit 2 enters load mode; the first loaded byte latches the row.
// - Once latched, accesses to other rows are dropped or read blank.
// - Entering parallel mode clears all eight row latches.
// - A parallel cycle programs only bytes loaded since entering the mode.
// - A row is eight bytes sharing upper address bits; A2..A0 pick a byte.
// - Start bit 3 launches the row cycle and clears itself at its end.
// - Parallel mode clears itself at the end of each parallel cycle.
// - Start is taken only with enable and parallel mode both set.
// - Clearing parallel mode before start abandons the row untouched.
// - The control register sits at DFh and resets to 00h.
// - Bank value 01 selects page 0, 02 page 1; one bit at most.
module deac_access #(
  parameter [15:0] PROG_CYCLES = `DEAC_PROG_CYCLES
) (
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  output reg         o_rd_hit,
  output reg  [6:0]  o_arr_addr,
  output reg         o_arr_rd,
  input  wire [7:0]  i_arr_rdata,
  output reg         o_prog_go,
  output reg  [3:0]  o_prog_row,
  output reg  [63:0] o_prog_data,
  output reg  [7:0]  o_prog_mask,
  output wire        o_busy,
  output wire        o_standby
);

  // ****************************************
  // Reset release.
  // ****************************************
  reg rst_meta_reg;
  reg rst_sync_reg;

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_sync_reg;

  // ****************************************
  // State and control storage.
  // ****************************************
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_LOAD = 3'b010;
  localparam [2:0] S_PROG = 3'b100;
  localparam [7:0] CTL_RESET = `DEAC_CTL_RESET;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [7:0]  bank_reg;
  reg         ena_reg;
  reg         standby_reg;
  reg         pstart_reg;
  reg         row_valid_reg;
  reg  [3:0]  row_reg;
  reg         rd_ee_reg;
  reg         rd_ctl_reg;
  reg         rd_blank_reg;
  reg         rd_busy_reg;
  wire [63:0] latch_data;
  wire [7:0]  latch_mask;
  wire        prog_done;

  wire busy      = state_reg[2];
  wire in_load   = state_reg[1];
  assign o_busy    = state_reg[2];
  assign o_standby = standby_reg;

  // ****************************************
  // Access decode.
  // ****************************************
  // window decode
  wire       in_win  = (i_addr <= `DEAC_WIN_LAST);
  wire       ee_sel  = (bank_reg == `DEAC_BANK_PAGE0) ||
                       (bank_reg == `DEAC_BANK_PAGE1);
  wire [3:0] cur_row = {bank_reg[1], i_addr[5:3]};
  wire       row_ok  = ~in_load | ~row_valid_reg | (cur_row == row_reg);
  wire       ee_ok   = ee_sel & ~standby_reg & ~busy;
  wire       ctl_wr  = i_wr & (i_addr == `DEAC_CTL_ADDR) & ~busy;
  wire       ee_wr   = i_wr & in_win & ee_ok & row_ok;

  wire byte_go   = ee_wr & state_reg[0] & ena_reg;
  wire par_enter = ctl_wr & i_wdata[`DEAC_BIT_ROW_WRITE] & state_reg[0];
  wire par_quit  = ctl_wr & ~i_wdata[`DEAC_BIT_ROW_WRITE] & in_load;
  wire par_go    = ctl_wr & in_load & i_wdata[`DEAC_BIT_PSTART] &
                   i_wdata[`DEAC_BIT_ENA] & i_wdata[`DEAC_BIT_ROW_WRITE] &
                   ~i_wdata[`DEAC_BIT_STBY];
  wire par_load  = ee_wr & in_load;

  // ****************************************
  // Submodules.
  // ****************************************
  // latches cleared on entry
  deac_row_latch #(
    .BYTES (`DEAC_ROW_BYTES)
  ) u_row_latch (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_n),
    .i_clear (par_enter | par_quit | (prog_done & pstart_reg)),
    .i_load  (par_load),
    .i_index (i_addr[2:0]),
    .i_data  (i_wdata),
    .o_data  (latch_data),
    .o_mask  (latch_mask)
  );

  deac_prog_timer #(
    .CW     (16),
    .CYCLES (PROG_CYCLES)
  ) u_prog_timer (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_n),
    .i_start (byte_go | par_go),
    .o_done  (prog_done)
  );

  // ****************************************
  // Mode state machine.
  // ****************************************
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (byte_go)
          state_next = S_PROG;
        else if (par_enter)
          state_next = S_LOAD;
      end
      S_LOAD:
      begin
        if (par_go)
          state_next = S_PROG;
        else if (par_quit)
          state_next = S_IDLE;
      end
      S_PROG:
      begin
        if (prog_done)
          state_next = S_IDLE;
      end
      default:
        state_next = S_IDLE;
    endcase
  end

  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // ****************************************
  // Control and bank registers.
  // ****************************************
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ena_reg       <= CTL_RESET[`DEAC_BIT_ENA];
      standby_reg   <= CTL_RESET[`DEAC_BIT_STBY];
      pstart_reg    <= CTL_RESET[`DEAC_BIT_PSTART];
      bank_reg      <= `DEAC_BANK_RESET;
      row_valid_reg <= 1'b0;
      row_reg       <= 4'h0;
    end
    else
    begin
      if (ctl_wr)
      begin
        standby_reg <= i_wdata[`DEAC_BIT_STBY];
        ena_reg     <= i_wdata[`DEAC_BIT_ENA];
      end
      if (i_wr && (i_addr == `DEAC_BANK_ADDR))
        bank_reg <= i_wdata;
      if (par_go)
        pstart_reg <= 1'b1;
      else if (prog_done)
        pstart_reg <= 1'b0;
      if (par_enter || par_quit || prog_done)
        row_valid_reg <= 1'b0;
      else if (par_load && !row_valid_reg)
      begin
        row_valid_reg <= 1'b1;
        row_reg       <= cur_row;
      end
    end
  end

  // ****************************************
  // Programming request to the cell array.
  // ****************************************
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_prog_go   <= 1'b0;
      o_prog_row  <= 4'h0;
      o_prog_data <= 64'h0;
      o_prog_mask <= 8'h00;
    end
    else
    begin
      o_prog_go <= byte_go | par_go;
      if (byte_go)
      begin
        o_prog_row  <= cur_row;
        o_prog_data <= {8{i_wdata}};
        o_prog_mask <= 8'h01 << i_addr[2:0];
      end
      else if (par_go)
      begin
        o_prog_row  <= row_reg;
        o_prog_data <= latch_data;
        o_prog_mask <= latch_mask;
      end
    end
  end

  // ****************************************
  // Read path, two cycles for every target.
  // ****************************************
  always @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_arr_addr   <= 7'h00;
      o_arr_rd     <= 1'b0;
      rd_ee_reg    <= 1'b0;
      rd_ctl_reg   <= 1'b0;
      rd_blank_reg <= 1'b0;
      rd_busy_reg  <= 1'b0;
      o_rdata      <= 8'h00;
      o_rd_hit     <= 1'b0;
    end
    else
    begin
      o_arr_rd     <= i_rd & in_win & ee_ok & row_ok;
      o_arr_addr   <= {bank_reg[1], i_addr[5:0]};
      rd_ee_reg    <= i_rd & in_win & ee_ok & row_ok;
      rd_blank_reg <= i_rd & in_win & ee_sel & ~(ee_ok & row_ok);
      rd_ctl_reg   <= i_rd & (i_addr == `DEAC_CTL_ADDR);
      rd_busy_reg  <= busy;
      o_rd_hit     <= rd_ee_reg | rd_blank_reg | rd_ctl_reg;
      if (rd_ee_reg)
        o_rdata <= i_arr_rdata;
      else if (rd_ctl_reg)
        o_rdata <= {6'h00, rd_busy_reg, 1'b0};
      else if (rd_blank_reg)
        o_rdata <= `DEAC_BLANK_DATA;
      else
        o_rdata <= 8'h00;
    end
  end

endmodule // deac_access

// ==== dv/deac_access_properties.sv ====
`timescale 1ns/1ps
// ****************************************
// Port checker for the access block.
// ****************************************
module deac_chk #(
  parameter [15:0] PROG_CYCLES = 16'h0008
) (
  input wire        i_ref_clk,
  input wire        i_rst_n,
  input wire [7:0]  i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [7:0]  o_rdata,
  input wire        o_rd_hit,
  input wire [6:0]  o_arr_addr,
  input wire        o_arr_rd,
  input wire [7:0]  i_arr_rdata,
  input wire        o_prog_go,
  input wire [3:0]  o_prog_row,
  input wire [7:0]  o_prog_mask,
  input wire        o_busy,
  input wire        o_standby
);
  reg [15:0] busy_cnt_reg;
  always @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      busy_cnt_reg <= 16'h0000;
    else
      busy_cnt_reg <= o_busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_ctl_req; i_rd && i_addr == 8'hdf; endsequence
  sequence s_arr_ans; ##1 o_rd_hit && o_rdata == $past(i_arr_rdata); endsequence
  sequence s_ctl_wr; i_wr && i_addr == 8'hdf; endsequence
  property p_busy_len; $fell(o_busy) |-> busy_cnt_reg == PROG_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_go_busy; (o_prog_go || $rose(o_busy)) |-> (o_prog_go && $rose(o_busy)); endproperty
  a_go_busy: assert property (p_go_busy) else $error("go and busy apart");
  property p_ctl_rd; s_ctl_req |-> ##2 o_rd_hit && o_rdata == {6'h00, $past(o_busy, 2), 1'b0}; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read wrong");
  property p_win_rd; o_arr_rd |-> $past(i_rd) && $past(i_addr) <= 8'h3f && o_arr_addr[5:0] == $past(i_addr[5:0]);
  endproperty
  a_win_rd: assert property (p_win_rd) else $error("array read address wrong");
  property p_arr_data; o_arr_rd |-> s_arr_ans; endproperty
  a_arr_data: assert property (p_arr_data) else $error("array data not returned");
  property p_no_hit; i_rd && i_addr == 8'hcb |-> ##2 !o_rd_hit; endproperty
  a_no_hit: assert property (p_no_hit) else $error("bank read answered");
  property p_ctl_lock; s_ctl_wr ##0 o_busy |=> !o_prog_go && $stable(o_standby); endproperty
  a_ctl_lock: assert property (p_ctl_lock) else $error("control changed while busy");
  property p_stby; s_ctl_wr ##0 !o_busy |=> o_standby == $past(i_wdata[6]); endproperty
  a_stby: assert property (p_stby) else $error("standby not taken");
  property p_hold; o_busy && !o_prog_go |-> $stable(o_prog_row) && $stable(o_prog_mask); endproperty
  a_hold: assert property (p_hold) else $error("row moved while busy");
endmodule // deac_chk

// ==== dv/deac_array_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Cell array seen by the access block.
// ****************************************
module deac_array_model (
  input  wire        i_clk,
  input  wire [6:0]  i_arr_addr,
  input  wire        i_arr_rd,
  output wire [7:0]  o_arr_rdata,
  input  wire        i_prog_go,
  input  wire [3:0]  i_prog_row,
  input  wire [63:0] i_prog_data,
  input  wire [7:0]  i_prog_mask
);
  reg [7:0] mem [0:127];
  reg [7:0] junk_reg;
  integer   k;
  initial
  begin
    junk_reg = 8'h00;
    for (k = 0; k < 128; k = k + 1)
      mem[k] = 8'hff;
  end
  // Outside a read strobe the data lines carry a moving pattern.
  assign o_arr_rdata = i_arr_rd ? mem[i_arr_addr] : junk_reg;
  always @(posedge i_clk)
  begin
    junk_reg <= junk_reg + 8'h5b;
    if (i_prog_go)
      for (k = 0; k < 8; k = k + 1)
        if (i_prog_mask[k])
          mem[{i_prog_row, k[2:0]}] <= i_prog_data[8*k +: 8];
  end
endmodule // deac_array_model

// ==== dv/deac_access_tb.sv ====
`timescale 1ns/1ps
// ****************************************
// Self-checking bench.
// ****************************************
module deac_access_tb;
  localparam [15:0] PC = 16'h0008;
  reg         i_ref_clk, i_rst_n, i_wr, i_rd;
  reg  [7:0]  i_addr, i_wdata, d;
  wire [7:0]  o_rdata, i_arr_rdata, o_prog_mask;
  wire        o_rd_hit, o_arr_rd, o_prog_go, o_busy, o_standby;
  wire [6:0]  o_arr_addr;
  wire [3:0]  o_prog_row;
  wire [63:0] o_prog_data;
  reg  [7:0]  exp_mem [0:127];
  integer     failures, num_checks, seed, cyc, gos, egos, i, a, pg;
  deac_access #(.PROG_CYCLES(PC)) uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rd_hit(o_rd_hit),
    .o_arr_addr(o_arr_addr), .o_arr_rd(o_arr_rd), .i_arr_rdata(i_arr_rdata), .o_prog_go(o_prog_go),
    .o_prog_row(o_prog_row), .o_prog_data(o_prog_data), .o_prog_mask(o_prog_mask), .o_busy(o_busy),
    .o_standby(o_standby));
  deac_array_model arr (.i_clk(i_ref_clk), .i_arr_addr(o_arr_addr), .i_arr_rd(o_arr_rd),
    .o_arr_rdata(i_arr_rdata), .i_prog_go(o_prog_go), .i_prog_row(o_prog_row),
    .i_prog_data(o_prog_data), .i_prog_mask(o_prog_mask));
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk)
  begin
    cyc = cyc + 1;
    if (o_prog_go === 1'b1)
      gos = gos + 1;
    if (cyc > 4000)
    begin
      failures = failures + 1;
      stop_test;
    end
  end
  function [6:0] fa(input integer p, input integer ad);
    fa = {p[0], ad[5:0]};
  endfunction
  task chk(input [63:0] seen, input [63:0] exp, input [8*10:1] wh);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("[ERR] %0s exp %h seen %h", wh, exp, seen);
    end
  end
  endtask
  task op(input w, input r, input [7:0] ad, input [7:0] wd);
  begin
    @(posedge i_ref_clk);
    #1;
    i_wr = w;
    i_rd = r;
    i_addr = ad;
    i_wdata = wd;
  end
  endtask
  task wr(input [7:0] ad, input [7:0] wd);
  begin
    op(1'b1, 1'b0, ad, wd);
    op(1'b0, 1'b0, 8'h00, 8'h00);
  end
  endtask
  task rd(input [7:0] ad, input h, input [7:0] e, input [8*10:1] wh);
  begin
    op(1'b0, 1'b1, ad, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    @(posedge i_ref_clk);
    #1;
    chk(o_rd_hit, h, wh);
    if (h)
      chk(o_rdata, e, wh);
  end
  endtask
  task idle;
    integer n;
  begin
    n = 0;
    @(posedge i_ref_clk);
    #1;
    while (o_busy !== 1'b0 && n < 40)
    begin
      @(posedge i_ref_clk);
      #1;
      n = n + 1;
    end
    chk(o_busy, 1'b0, "busy_end");
    chk(gos, egos, "go_count");
  end
  endtask
  task stop_test;
  begin
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  initial
  begin
    {i_ref_clk, i_rst_n, i_wr, i_rd, i_addr, i_wdata} = 0;
    {failures, num_checks, cyc, gos, egos} = 0;
    seed = 32'h6e89;
    for (i = 0; i < 128; i = i + 1)
      exp_mem[i] = 8'hff;
    repeat (3) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    rd(8'hdf, 1'b1, 8'h00, "ctl_reset");
    rd(8'hcb, 1'b0, 8'h00, "bank_rd");
    wr(8'hdf, 8'h01);
    wr(8'h05, 8'h12);
    idle;
    for (i = 0; i < 8; i = i + 1)
    begin
      pg = $random(seed) & 1;
      a = (i == 0) ? 0 : (i == 1) ? 63 : $random(seed) & 63;
      d = $random(seed);
      wr(8'hcb, 8'h00);
      wr(pg[7:0] + 8'h01, 8'h00);
      wr(8'hcb, pg[7:0] + 8'h01);
      wr(8'hdf, 8'h01);
      wr(a[7:0], d);
      exp_mem[fa(pg, a)] = d;
      egos = egos + 1;
      wr(8'hdf, 8'h40);
      wr(a[7:0], ~d);
      rd(8'hdf, 1'b1, 8'h02, "ctl_busy");
      idle;
      chk(o_standby, 1'b0, "stby_lock");
      rd(a[7:0], 1'b1, exp_mem[fa(pg, a)], "byte_rd");
    end
    wr(8'hcb, 8'h01);
    wr(8'hdf, 8'h00);
    wr(8'h07, 8'h3c);
    idle;
    wr(8'hdf, 8'h41);
    chk(o_standby, 1'b1, "stby_on");
    rd(8'h07, 1'b1, 8'hff, "stby_rd");
    wr(8'h07, 8'h3c);
    idle;
    wr(8'hdf, 8'h05);
    wr(8'h18, 8'h77);
    wr(8'h19, 8'h66);
    wr(8'hdf, 8'h01);
    idle;
    wr(8'hdf, 8'h05);
    for (i = 0; i < 4; i = i + 1)
    begin
      a = (i == 0) ? 8'h18 : (i == 1) ? 8'h1a : (i == 2) ? 8'h1b : 8'h21;
      d = $random(seed);
      wr(a[7:0], d);
      if (i < 3)
        exp_mem[a] = d;
    end
    wr(8'hdf, 8'h0d);
    egos = egos + 1;
    idle;
    chk(o_prog_mask, 8'h0d, "row_mask");
    chk(o_prog_row, 4'h3, "row_addr");
    wr(8'hdf, 8'h0d);
    wr(8'hdf, 8'h04);
    wr(8'h18, 8'h00);
    wr(8'hdf, 8'h0c);
    wr(8'hdf, 8'h00);
    idle;
    for (pg = 0; pg < 2; pg = pg + 1)
    begin
      wr(8'hcb, pg[7:0] + 8'h01);
      for (i = 0; i < 64; i = i + 1)
        rd(i[7:0], 1'b1, exp_mem[fa(pg, i)], "sweep");
    end
    stop_test;
  end
endmodule // deac_access_tb
bind deac_access deac_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rd_hit(o_rd_hit),
  .o_arr_addr(o_arr_addr), .o_arr_rd(o_arr_rd), .i_arr_rdata(i_arr_rdata), .o_prog_go(o_prog_go),
  .o_prog_row(o_prog_row), .o_prog_mask(o_prog_mask), .o_busy(o_busy), .o_standby(o_standby));
